// File: adc_seq_pkg.sv
// Package with register map, field positions and reset values of the result buffer sequencer
package adc_seq_pkg;
  // Register word indices on the plain register port
  localparam logic [5:0] BUF_BASE_ADDR = 6'h00;
  localparam logic [5:0] BUF_LAST_ADDR = 6'h0f;
  localparam logic [5:0] CONTROL_ONE_ADDR = 6'h10;
  localparam logic [5:0] CONTROL_TWO_ADDR = 6'h11;
  localparam logic [5:0] INPUT_SELECT_ADDR = 6'h12;
  localparam logic [5:0] SCAN_MASK_ADDR = 6'h13;

  // Widths
  localparam int RESULT_W = 12;
  localparam int WORD_W = 16;
  localparam int DEPTH = 16;

  // Control one fields
  localparam int ONE_CONVERTER_ON_BIT = 15;
  localparam int ONE_FORMAT_LSB = 8;
  localparam int ONE_AUTO_SAMPLE_BIT = 2;
  localparam int ONE_SAMPLING_BIT = 1;
  localparam int ONE_DONE_BIT = 0;

  // Control two fields
  localparam int TWO_SCAN_ENABLE_BIT = 10;
  localparam int TWO_FILL_HALF_BIT = 7;
  localparam int TWO_SPI_LSB = 2;
  localparam int TWO_SPLIT_MODE_BIT = 1;
  localparam int TWO_ALT_SELECT_BIT = 0;

  // Input select fields
  localparam int SEL_A_POS_LSB = 0;
  localparam int SEL_A_NEG_BIT = 7;
  localparam int SEL_B_POS_LSB = 8;
  localparam int SEL_B_NEG_BIT = 15;

  // Reset values
  localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_TWO_RESET = 16'h0000;
  localparam logic [15:0] INPUT_SELECT_RESET = 16'h0000;
  localparam logic [15:0] SCAN_MASK_RESET = 16'h0000;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  // Output format encodings
  localparam logic [1:0] FORMAT_INTEGER = 2'h0;
  localparam logic [1:0] FORMAT_SIGNED_INTEGER = 2'h1;
  localparam logic [1:0] FORMAT_FRACTIONAL = 2'h2;
  localparam logic [1:0] FORMAT_SIGNED_FRACTIONAL = 2'h3;

  // Upper half starts here in split-buffer mode
  localparam logic [3:0] UPPER_HALF_BASE = 4'h8;
endpackage

// File: adc_result_formatter.sv
// Formats a raw 12-bit result into one of four 16-bit bus words
`timescale 1ns/1ps
module adc_result_formatter (
  input wire logic [11:0] i_raw,
  input wire logic [1:0] i_output_format,
  output logic [15:0] o_word
);
  // Offset-binary to signed works by inverting the top bit and extending it
  always_comb begin
    case (i_output_format)
      adc_seq_pkg::FORMAT_INTEGER: begin
        o_word = {4'h0, i_raw};
      end
      adc_seq_pkg::FORMAT_SIGNED_INTEGER: begin
        o_word = {{5{~i_raw[11]}}, i_raw[10:0]};
      end
      adc_seq_pkg::FORMAT_FRACTIONAL: begin
        o_word = {i_raw, 4'h0};
      end
      adc_seq_pkg::FORMAT_SIGNED_FRACTIONAL: begin
        o_word = {~i_raw[11], i_raw[10:0], 4'h0};
      end
      default: begin
        o_word = 16'h0000;
      end
    endcase
  end
endmodule

// File: adc_result_buffer_sequencer.sv
// Result buffer write sequencer with split-buffer, scan and register port
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Operation
// RULE1 - Completed results are kept in sixteen twelve-bit words.
// RULE2 - Sixteen result words appear at sixteen consecutive register addresses.
// RULE3 - Field bits 5:2 of control two sets conversions per interrupt, one to sixteen.
// RULE4 - After the configured count of results, pulse the conversion-complete interrupt.
// RULE5 - After each interrupt, writing restarts at the first word of the region.
// RULE6 - A zero count field writes every result to word zero only; in split-buffer mode the code alternates words 0 and 8.
// RULE7 - Successive results go to successive words, offset zero upward.
// RULE8 - Software keeps the count at eight or less in split-buffer mode.
// RULE9 - Split-buffer mode uses two eight-word halves, swapping after each interrupt.
// RULE10 - Newly enabled split mode starts filling the lower half.
// RULE11 - Without split mode the whole sixteen words output_format one region.
// RULE12 - Read-only bit 7 of control two shows the half being filled.
// RULE13 - Status zero means words 0-7 fill, one means words 8-15 fill.
// RULE14 - Without split mode, word zero is rewritten after one more conversion.
// RULE15 - Software uses split mode when it cannot unload within one conversion.
// RULE16 - Auto-sample bit starts sampling; a trigger ends it and starts conversion.
// RULE17 - With alternate select clear only multiplexer A selections are used.
// RULE18 - Negative select zero connects the negative reference to the amplifier.
// RULE19 - Scan enable steps the positive input through the scan mask.
// RULE20 - Scan runs ascending from input zero and restarts after each interrupt.
// RULE21 - Reads return a sixteen-bit word in one of four output formats.
// RULE22 - Turning the converter off aborts conversion without writing the buffer.
// RULE23 - Fill status toggles at the interrupt that swaps the half.
// RULE24 - Processor writes to buffer addresses leave stored results unchanged.
module adc_result_buffer_sequencer (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [5:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_conv_trigger,
  input wire logic i_conv_done,
  input wire logic [11:0] i_conv_result,
  output logic o_sampling,
  output logic o_convert_start,
  output logic o_conv_abort,
  output logic [3:0] o_pos_select,
  output logic o_neg_select,
  output logic o_conv_complete_irq
);
  typedef enum {IDLE, SAMPLE, CONVERT} seq_state_e;

  seq_state_e state;
  seq_state_e next_state;
  logic converter_on;
  logic [1:0] output_format;
  logic auto_sample_enable;
  logic done;
  logic scan_enable;
  logic fill_half_status;
  logic [3:0] samples_per_irq;
  logic split_buffer_mode;
  logic split_prev;
  logic alternate_input_select;
  logic use_mux_b;
  logic [3:0] mux_a_positive_select;
  logic mux_a_negative_select;
  logic [3:0] mux_b_positive_select;
  logic mux_b_negative_select;
  logic [15:0] scan_select_mask;
  logic [3:0] scan_channel;
  logic [3:0] seq_count;
  logic [3:0] limit;
  logic [3:0] wr_addr;
  logic buf_we;
  logic seq_end;
  logic [15:0][11:0] result_memory;
  logic [15:0] formatted;
  logic wr_one;
  logic sw_sample_start;
  logic sw_sample_stop;
  logic is_buf_addr;

  assign wr_one = i_wr && (i_addr == adc_seq_pkg::CONTROL_ONE_ADDR);
  assign is_buf_addr = (i_addr <= adc_seq_pkg::BUF_LAST_ADDR);
  assign sw_sample_start = wr_one && i_wdata[adc_seq_pkg::ONE_SAMPLING_BIT];
  assign sw_sample_stop = wr_one && !i_wdata[adc_seq_pkg::ONE_SAMPLING_BIT];

  // Control one: software owned fields
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      converter_on <= adc_seq_pkg::CONTROL_ONE_RESET[adc_seq_pkg::ONE_CONVERTER_ON_BIT];
      output_format <= adc_seq_pkg::CONTROL_ONE_RESET[adc_seq_pkg::ONE_FORMAT_LSB +: 2];
      auto_sample_enable <= adc_seq_pkg::CONTROL_ONE_RESET[adc_seq_pkg::ONE_AUTO_SAMPLE_BIT];
    end else if (wr_one) begin
      converter_on <= i_wdata[adc_seq_pkg::ONE_CONVERTER_ON_BIT];
      output_format <= i_wdata[adc_seq_pkg::ONE_FORMAT_LSB +: 2];
      auto_sample_enable <= i_wdata[adc_seq_pkg::ONE_AUTO_SAMPLE_BIT];
    end
  end

  // Done flag: a completion in the same cycle as a software clear wins
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      done <= adc_seq_pkg::CONTROL_ONE_RESET[adc_seq_pkg::ONE_DONE_BIT];
    end else if (buf_we) begin
      done <= 1'b1;
    end else if (wr_one && !i_wdata[adc_seq_pkg::ONE_DONE_BIT]) begin
      done <= 1'b0;
    end
  end

  // Control two, input select and scan mask; fill status bit is not writable
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      scan_enable <= adc_seq_pkg::CONTROL_TWO_RESET[adc_seq_pkg::TWO_SCAN_ENABLE_BIT];
      samples_per_irq <= adc_seq_pkg::CONTROL_TWO_RESET[adc_seq_pkg::TWO_SPI_LSB +: 4];
      split_buffer_mode <= adc_seq_pkg::CONTROL_TWO_RESET[adc_seq_pkg::TWO_SPLIT_MODE_BIT];
      alternate_input_select <= adc_seq_pkg::CONTROL_TWO_RESET[adc_seq_pkg::TWO_ALT_SELECT_BIT];
      mux_a_positive_select <= adc_seq_pkg::INPUT_SELECT_RESET[adc_seq_pkg::SEL_A_POS_LSB +: 4];
      mux_a_negative_select <= adc_seq_pkg::INPUT_SELECT_RESET[adc_seq_pkg::SEL_A_NEG_BIT];
      mux_b_positive_select <= adc_seq_pkg::INPUT_SELECT_RESET[adc_seq_pkg::SEL_B_POS_LSB +: 4];
      mux_b_negative_select <= adc_seq_pkg::INPUT_SELECT_RESET[adc_seq_pkg::SEL_B_NEG_BIT];
      scan_select_mask <= adc_seq_pkg::SCAN_MASK_RESET;
    end else if (i_wr) begin
      if (i_addr == adc_seq_pkg::CONTROL_TWO_ADDR) begin
        scan_enable <= i_wdata[adc_seq_pkg::TWO_SCAN_ENABLE_BIT];
        samples_per_irq <= i_wdata[adc_seq_pkg::TWO_SPI_LSB +: 4]; // RULE3
        split_buffer_mode <= i_wdata[adc_seq_pkg::TWO_SPLIT_MODE_BIT];
        alternate_input_select <= i_wdata[adc_seq_pkg::TWO_ALT_SELECT_BIT];
      end
      if (i_addr == adc_seq_pkg::INPUT_SELECT_ADDR) begin
        mux_a_positive_select <= i_wdata[adc_seq_pkg::SEL_A_POS_LSB +: 4];
        mux_a_negative_select <= i_wdata[adc_seq_pkg::SEL_A_NEG_BIT];
        mux_b_positive_select <= i_wdata[adc_seq_pkg::SEL_B_POS_LSB +: 4];
        mux_b_negative_select <= i_wdata[adc_seq_pkg::SEL_B_NEG_BIT];
      end
      if (i_addr == adc_seq_pkg::SCAN_MASK_ADDR) begin
        scan_select_mask <= i_wdata;
      end
    end
  end

  // Sequencer: sample until trigger, convert until done, abort when switched off
  always_comb begin
    next_state = state;
    case (state)
      IDLE: begin
        if (converter_on && (auto_sample_enable || sw_sample_start)) begin
          next_state = SAMPLE; // RULE16
        end
      end
      SAMPLE: begin
        if (!converter_on) begin
          next_state = IDLE;
        end else if (i_conv_trigger || (sw_sample_stop && !auto_sample_enable)) begin
          next_state = CONVERT; // RULE16
        end
      end
      CONVERT: begin
        if (!converter_on) begin
          next_state = IDLE; // RULE22
        end else if (i_conv_done) begin
          next_state = auto_sample_enable ? SAMPLE : IDLE;
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Converter handshake toward the analog side
  assign o_sampling = (state == SAMPLE);
  assign o_convert_start = (state == SAMPLE) && (next_state == CONVERT);
  assign o_conv_abort = (state == CONVERT) && !converter_on; // RULE22

  // A result is accepted only while a conversion is live, so an abort never writes
  assign buf_we = (state == CONVERT) && converter_on && i_conv_done; // RULE22

  // Region size: count field plus one; in split mode only the low three bits of the field count
  assign limit = split_buffer_mode ? {1'b0, samples_per_irq[2:0]} : samples_per_irq; // RULE8 RULE11
  assign seq_end = buf_we && (seq_count == limit); // RULE4
  assign wr_addr = split_buffer_mode ? {fill_half_status, seq_count[2:0]} : seq_count; // RULE9 RULE13
  assign o_conv_complete_irq = seq_end;

  // Write pointer: ascending within a sequence, back to zero at each interrupt
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      seq_count <= 4'h0;
    end else if (seq_end) begin
      seq_count <= 4'h0; // RULE5 RULE6 RULE14
    end else if (buf_we) begin
      seq_count <= seq_count + 4'h1; // RULE7
    end
  end

  // Half select: lower half on entry to split mode, swaps at each interrupt
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      split_prev <= 1'b0;
      fill_half_status <= 1'b0;
    end else begin
      split_prev <= split_buffer_mode;
      if (!split_buffer_mode || !split_prev) begin
        fill_half_status <= 1'b0; // RULE10
      end else if (seq_end) begin
        fill_half_status <= ~fill_half_status; // RULE9 RULE23
      end
    end
  end

  // Lowest enabled scan input at or above a start point, else the lowest enabled one; an empty mask gives input zero
  function automatic logic [3:0] next_enabled(input logic [15:0] mask, input logic [4:0] start);
    logic [3:0] pick;
    logic found;
    pick = 4'h0;
    found = 1'b0;
    for (int k = 0; k < 16; k++) begin
      if (!found && mask[k] && (5'(k) >= start)) begin
        pick = 4'(k);
        found = 1'b1;
      end
    end
    if (!found) begin
      for (int k = 15; k >= 0; k--) begin
        if (mask[k]) begin
          pick = 4'(k);
        end
      end
    end
    return pick;
  endfunction

  // Scan position and mux B alternation both restart with each sequence
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      scan_channel <= 4'h0;
      use_mux_b <= 1'b0;
    end else if (seq_end || !scan_enable && !alternate_input_select) begin
      scan_channel <= next_enabled(scan_select_mask, 5'h00); // RULE20
      use_mux_b <= 1'b0;
    end else if (buf_we) begin
      scan_channel <= next_enabled(scan_select_mask, {1'b0, scan_channel} + 5'h01); // RULE20
      use_mux_b <= alternate_input_select && !use_mux_b;
    end else if (state == IDLE && seq_count == 4'h0) begin
      scan_channel <= next_enabled(scan_select_mask, 5'h00);
    end
  end

  // Input selection: scan overrides the fixed positive choice of mux A only
  always_comb begin
    if (use_mux_b && alternate_input_select) begin
      o_pos_select = mux_b_positive_select;
      o_neg_select = mux_b_negative_select;
    end else begin
      o_pos_select = scan_enable ? scan_channel : mux_a_positive_select; // RULE17 RULE19
      o_neg_select = mux_a_negative_select; // RULE18
    end
  end

  // Result memory, one flip-flop word per entry, written only by the converter
  generate
    for (genvar g = 0; g < adc_seq_pkg::DEPTH; g++) begin : g_word
      always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
          result_memory[g] <= adc_seq_pkg::RESULT_RESET;
        end else if (buf_we && wr_addr == 4'(g)) begin
          result_memory[g] <= i_conv_result; // RULE1 RULE24
        end
      end
    end
  endgenerate

  adc_result_formatter u_formatter (
    .i_raw(result_memory[i_addr[3:0]]),
    .i_output_format(output_format),
    .o_word(formatted)
  );

  // Read data stand only in the cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else if (!i_rd) begin
      o_rdata <= 16'h0000;
    end else if (is_buf_addr) begin
      o_rdata <= formatted; // RULE2 RULE21
    end else begin
      case (i_addr)
        adc_seq_pkg::CONTROL_ONE_ADDR: begin
          o_rdata <= {converter_on, 5'h00, output_format, 5'h00, auto_sample_enable,
                      (state == SAMPLE), done};
        end
        adc_seq_pkg::CONTROL_TWO_ADDR: begin
          o_rdata <= {5'h00, scan_enable, 2'h0, fill_half_status, 1'b0, samples_per_irq,
                      split_buffer_mode, alternate_input_select}; // RULE12
        end
        adc_seq_pkg::INPUT_SELECT_ADDR: begin
          o_rdata <= {mux_b_negative_select, 3'h0, mux_b_positive_select,
                      mux_a_negative_select, 3'h0, mux_a_positive_select};
        end
        adc_seq_pkg::SCAN_MASK_ADDR: begin
          o_rdata <= scan_select_mask;
        end
        default: begin
          o_rdata <= 16'h0000;
        end
      endcase
    end
  end

  // Last written word; a control two write ends the check, since the count may change under it
  logic [3:0] last_wr_addr;
  logic mid_seq;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      last_wr_addr <= 4'h0;
      mid_seq <= 1'b0;
    end else if (i_wr && i_addr == adc_seq_pkg::CONTROL_TWO_ADDR) begin
      mid_seq <= 1'b0;
    end else if (buf_we) begin
      last_wr_addr <= wr_addr;
      mid_seq <= !seq_end;
    end
  end

  // Checks on the write sequencing and register view
  a_irq_at_count: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE4
    o_conv_complete_irq |-> buf_we && seq_count == limit) else $error("interrupt not at configured count");
  a_ptr_restart_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
    o_conv_complete_irq |=> seq_count == 4'h0) else $error("pointer did not restart");
  a_zero_count_word0: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE6
    buf_we && samples_per_irq == 4'h0 && !split_buffer_mode |-> wr_addr == 4'h0)
    else $error("zero count wrote beyond word zero");
  a_ascending_write: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE7
    buf_we && mid_seq && !split_buffer_mode |-> wr_addr == last_wr_addr + 4'h1)
    else $error("write address did not advance");
  a_split_half_addr: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE13
    buf_we && split_buffer_mode |-> wr_addr[3] == fill_half_status) else $error("write outside fill half");
  a_split_lower_first: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE10
    $rose(split_buffer_mode) |=> !fill_half_status) else $error("split mode did not start low");
  a_fill_toggle: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE23
    o_conv_complete_irq && split_buffer_mode && split_prev && $past(split_buffer_mode)
    |=> fill_half_status != $past(fill_half_status)) else $error("fill status did not toggle");
  a_abort_no_write: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE22
    !converter_on |=> $stable(result_memory)) else $error("buffer written while converter off");
  a_mux_a_only: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE17
    !alternate_input_select && !scan_enable && $past(!alternate_input_select)
    |-> o_pos_select == mux_a_positive_select && o_neg_select == mux_a_negative_select)
    else $error("mux B used with alternate select clear");
  a_trigger_converts: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE16
    state == SAMPLE && converter_on && i_conv_trigger |-> o_convert_start ##1 state == CONVERT)
    else $error("trigger did not start conversion");
  a_read_only_buf: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE24
    i_wr && is_buf_addr && !buf_we |=> $stable(result_memory)) else $error("processor write changed buffer");

  c_split_irq: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    o_conv_complete_irq && split_buffer_mode && fill_half_status);
  c_scan_write: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    buf_we && scan_enable && scan_channel != 4'h0);
  c_abort: cover property (@(posedge i_sys_clk) disable iff (i_reset) o_conv_abort);
  c_full_sixteen: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    o_conv_complete_irq && wr_addr == 4'hf);
endmodule

// File: adc_converter_model.sv
// Behavioural converter that answers each conversion start with a one-cycle done pulse
`timescale 1ns/1ps
module adc_converter_model (
  input wire logic i_sys_clk,
  input wire logic i_convert_start,
  input wire logic [3:0] i_latency,
  input wire logic [11:0] i_value,
  output logic o_conv_done,
  output logic [11:0] o_conv_result
);
  logic [11:0] held;
  // Result is valid only beside done; afterwards the inverse shows, so a stale value never matches
  initial begin
    o_conv_done = 1'b0;
    o_conv_result = 12'hfff;
    held = 12'h000;
    forever begin
      @(posedge i_sys_clk);
      if (i_convert_start === 1'b1) begin
        held = i_value;
        repeat (i_latency) @(posedge i_sys_clk);
        o_conv_done <= 1'b1;
        o_conv_result <= held;
        @(posedge i_sys_clk);
        o_conv_done <= 1'b0;
        o_conv_result <= ~held;
      end
    end
  end
endmodule

// File: adc_result_buffer_sequencer_tb.sv
// Self-checking bench for the result buffer sequencer against a behavioural buffer model
`timescale 1ns/1ps
module adc_result_buffer_sequencer_tb;
  logic clk, rst, wr, rd, trig, done, smp, cstart, abort, neg, irq;
  logic [5:0] addr;
  logic [15:0] wdata, rdata, insel, mask;
  logic [11:0] res, val;
  logic [3:0] pos, lat;
  int bad_count, tests_run, cycles, cnt, half, spi, split, scan, sidx;
  int mem[16];
  int scan_list[$];

  adc_result_buffer_sequencer u_dut (.i_sys_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_conv_trigger(trig), .i_conv_done(done), .i_conv_result(res),
    .o_sampling(smp), .o_convert_start(cstart), .o_conv_abort(abort), .o_pos_select(pos), .o_neg_select(neg),
    .o_conv_complete_irq(irq));
  adc_converter_model u_conv (.i_sys_clk(clk), .i_convert_start(cstart), .i_latency(lat), .i_value(val),
    .o_conv_done(done), .o_conv_result(res));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus cycles: strobes last one cycle, read data stands only in the following cycle
  task automatic reg_wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [5:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, exp, rdata);
  endtask

  task automatic read_all();
    for (int a = 0; a < 16; a++) reg_rd(6'(a), 16'(mem[a]), "buffer word");
  endtask

  function automatic logic [15:0] fmt(input logic [11:0] d, input int f);
    case (f)
      0: return {4'h0, d};
      1: return {{5{~d[11]}}, d[10:0]};
      2: return {d, 4'h0};
      default: return {~d[11], d[10:0], 4'h0};
    endcase
  endfunction

  // Reset, clear the model, configure and switch on with automatic sampling
  task automatic setup(input logic [15:0] ctl2, input logic [15:0] sel, input logic [15:0] msk);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (mem[i]) mem[i] = 0;
    cnt = 0;
    half = 0;
    sidx = 0;
    spi = int'(ctl2[5:2]);
    split = int'(ctl2[1]);
    scan = int'(ctl2[10]);
    insel = sel;
    scan_list.delete();
    for (int i = 0; i < 16; i++) if (msk[i]) scan_list.push_back(i);
    reg_wr(6'h12, sel);
    reg_wr(6'h13, msk);
    reg_wr(6'h11, ctl2);
    reg_wr(6'h10, 16'h8004);
  endtask

  // One sample/convert cycle; the model predicts the target word and the interrupt
  task automatic conv_one();
    int n;
    int a;
    logic last;
    n = 0;
    @(posedge clk);
    #1;
    while (smp !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("sampling", 16'h0001, 16'(smp));
    check("pos select", 16'(scan ? scan_list[sidx] : int'(insel[3:0])), 16'(pos));
    check("neg select", 16'h0000, 16'(neg));
    @(posedge clk);
    trig <= 1'b1;
    lat <= 4'($urandom_range(1, 4));
    val <= 12'($urandom);
    @(posedge clk);
    trig <= 1'b0;
    #1;
    check("sampling after trigger", 16'h0000, 16'(smp));
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
    a = split ? half * 8 + cnt : cnt;
    last = (cnt + 1 == (split ? spi % 8 + 1 : spi + 1));
    check("complete irq", 16'(last), 16'(irq));
    mem[a] = int'(val);
    cnt = last ? 0 : cnt + 1;
    sidx = last ? 0 : sidx + 1;
    if (last && split) half = 1 - half;
  endtask

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    trig = 1'b0;
    addr = 6'h00;
    wdata = 16'h0000;
    lat = 4'h1;
    val = 12'h000;
    void'($urandom(55));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 16; a < 20; a++) reg_rd(6'(a), 16'h0000, "control reset value");
    reg_rd(6'h3f, 16'h0000, "unmapped read");
    @(posedge clk);
    #1;
    check("read data idle", 16'h0000, rdata);
    read_all();
    $display("Test reset values done");

    setup(16'h003c, 16'($urandom) & 16'hff7f, 16'h0000);
    repeat (16) conv_one();
    read_all();
    conv_one();
    reg_rd(6'h00, 16'(mem[0]), "word zero rewritten");
    reg_wr(6'h05, 16'($urandom));
    reg_rd(6'h05, 16'(mem[5]), "buffer after write");
    for (int f = 0; f < 4; f++) begin
      reg_wr(6'h10, 16'h8004 | 16'(f << 8));
      reg_rd(6'h00, fmt(12'(mem[0]), f), "formatted word");
    end
    $display("Test single region done");

    setup(16'h0000, 16'h0000, 16'h0000);
    repeat (3) conv_one();
    repeat (2) @(posedge clk);
    trig <= 1'b1;
    lat <= 4'd9;
    val <= ~val;
    @(posedge clk);
    trig <= 1'b0;
    reg_wr(6'h10, 16'h0000);
    #1;
    check("abort", 16'h0001, 16'(abort));
    repeat (12) @(posedge clk);
    read_all();
    $display("Test single word and abort done");

    // Split mode kept at four per interrupt, within the eight allowed
    setup(16'h000e, 16'h0000, 16'h0000);
    reg_rd(6'h11, 16'h000e, "fill half at enable");
    repeat (4) conv_one();
    reg_rd(6'h11, 16'h008e, "fill half upper");
    repeat (4) conv_one();
    reg_rd(6'h11, 16'h000e, "fill half lower");
    read_all();
    // Leave the upper half selected, then switch split mode off and on again
    repeat (4) conv_one();
    reg_wr(6'h11, 16'h000c);
    reg_wr(6'h11, 16'h000e);
    reg_rd(6'h11, 16'h000e, "fill half re-enable");
    $display("Test split buffer done");

    mask = 16'($urandom) | 16'h0001;
    setup(16'h0400 | 16'(($countones(mask) - 1) << 2), 16'h0000, mask);
    repeat (scan_list.size() + 1) conv_one();
    read_all();
    $display("Test scan done");
    report_and_stop();
  end
endmodule
